// ---- logic/zvm_cfg.svh ----
// Purpose: constants for the zoomed video port routing block
// Assumes: included by bare name from the package and the modules
// Notes:   offsets, reset values and priority codes live here only
//
// Behaviour
// - drive enable clear holds video port terminals high-impedance; set drives them
// - source select picks socket 0 or socket 1 video, if enabled
// - auto source detection works only while the auto-detect bit is set
// - priority field is ignored unless auto-detect is set
// - priority codes 000 to 100 give the five documented source orders
// - socket 1 video mode takes card input, disables that card's drivers
// - socket 0 video mode takes card input, disables that card's drivers
`ifndef ZVM_CFG_SVH
`define ZVM_CFG_SVH

`define ZVM_VID_W       16
`define ZVM_CTRL_OFF    8'h84
`define ZVM_CTRL_RST    8'h00
`define ZVM_RD_IDLE     8'h00
`define ZVM_PRIO_ABE    3'h0
`define ZVM_PRIO_AEB    3'h1
`define ZVM_PRIO_BAE    3'h2
`define ZVM_PRIO_BEA    3'h3
`define ZVM_PRIO_EAB    3'h4
`define ZVM_IDX_A       2'h0
`define ZVM_IDX_B       2'h1
`define ZVM_IDX_E       2'h2

`endif

// ---- logic/zvm_pkg.sv ----
// Purpose: shared types for the zoomed video port routing block
// Assumes: zvm_cfg.svh supplies the widths
// Notes:   control fields are packed msb first to match the register bits
`include "zvm_cfg.svh"

package zvm_pkg;

    // routing control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       drive_en;     // video_out_drive_enable
        logic       src_sel;      // video_source_select
        logic       auto_en;      // video_source_priority_order_enable
        logic [2:0] prio;         // source_priority_order
        logic       s1_mode;      // socket1_video_mode
        logic       s0_mode;      // socket0_video_mode
    } zvm_ctrl_t;

    // chosen source, one-hot
    typedef enum logic [3:0] {
        ZVM_SRC_NONE = 4'h1,
        ZVM_SRC_S0   = 4'h2,
        ZVM_SRC_S1   = 4'h4,
        ZVM_SRC_EXT  = 4'h8
    } zvm_src_t;

    // one video source as seen at the pins
    typedef struct packed {
        logic                  present;
        logic [`ZVM_VID_W-1:0] data;
    } zvm_vid_t;

    // whole state of the routing block
    typedef struct packed {
        zvm_ctrl_t                  ctrl;
        zvm_vid_t  [2:0]            sync1;   // first stage, read only by sync2
        zvm_vid_t  [2:0]            sync2;
        logic      [`ZVM_VID_W-1:0] out_data;
        logic                       out_oe;
        logic                       card0_oe;
        logic                       card1_oe;
        zvm_src_t                   src;
        logic      [7:0]            rdata;
    } zvm_state_t;

endpackage : zvm_pkg

// ---- logic/zvm_prio.sv ----
// Purpose: picks the first available video source in a programmed order
// Assumes: avail bit 0 is slot A, bit 1 slot B, bit 2 the external source
// Notes:   purely combinational; codes above 100 fall back to the 100 order
`timescale 1ns/10ps
`include "zvm_cfg.svh"

module zvm_prio (
    input  wire logic [2:0]       code,
    input  wire logic [2:0]       avail,
    output zvm_pkg::zvm_src_t     pick
);

    logic [1:0] first;
    logic [1:0] second;
    logic [1:0] third;
    logic [1:0] win;
    logic       any;

    // order table for each priority code
    always_comb begin
        first  = `ZVM_IDX_E;
        second = `ZVM_IDX_A;
        third  = `ZVM_IDX_B;
        case (code)
            `ZVM_PRIO_ABE: begin first = `ZVM_IDX_A; second = `ZVM_IDX_B; third = `ZVM_IDX_E; end
            `ZVM_PRIO_AEB: begin first = `ZVM_IDX_A; second = `ZVM_IDX_E; third = `ZVM_IDX_B; end
            `ZVM_PRIO_BAE: begin first = `ZVM_IDX_B; second = `ZVM_IDX_A; third = `ZVM_IDX_E; end
            `ZVM_PRIO_BEA: begin first = `ZVM_IDX_B; second = `ZVM_IDX_E; third = `ZVM_IDX_A; end
            // reserved codes share the external-first order; safest guess
            default: begin first = `ZVM_IDX_E; second = `ZVM_IDX_A; third = `ZVM_IDX_B; end
        endcase
    end

    // first available source in order wins
    always_comb begin
        any = 1'b1;
        if (avail[first]) begin
            win = first;
        end else if (avail[second]) begin
            win = second;
        end else if (avail[third]) begin
            win = third;
        end else begin
            win = first;
            any = 1'b0;
        end
        if (!any) begin
            pick = zvm_pkg::ZVM_SRC_NONE;
        end else if (win == `ZVM_IDX_A) begin
            pick = zvm_pkg::ZVM_SRC_S0;
        end else if (win == `ZVM_IDX_B) begin
            pick = zvm_pkg::ZVM_SRC_S1;
        end else begin
            pick = zvm_pkg::ZVM_SRC_EXT;
        end
    end

endmodule : zvm_prio

// ---- logic/zvm_mux.sv ----
// Purpose: zoomed video port routing, source selection and drive control
// Assumes: config access signals come from logic on clk_sys; video pins do not
// Notes:   register answers at offset 84h in either function; reads lag one cycle
`timescale 1ns/10ps
`include "zvm_cfg.svh"

module zvm_mux (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  cfg_func,
    input  wire logic [7:0]            cfg_addr,
    input  wire logic                  cfg_wr,
    input  wire logic                  cfg_rd,
    input  wire logic [7:0]            cfg_wdata,
    output      logic [7:0]            cfg_rdata,
    input  wire logic [`ZVM_VID_W-1:0] sock0_vid_i,
    input  wire logic                  sock0_vid_present,
    input  wire logic [`ZVM_VID_W-1:0] sock1_vid_i,
    input  wire logic                  sock1_vid_present,
    input  wire logic [`ZVM_VID_W-1:0] ext_vid_i,
    input  wire logic                  ext_vid_present,
    output      logic [`ZVM_VID_W-1:0] vid_out_o,
    output      logic                  vid_out_oe,
    output      logic                  card0_if_oe,
    output      logic                  card1_if_oe,
    output      logic [3:0]            active_src
);

    ////////////////////////////////////////////////////////////////////////////
    // state and decode

    zvm_pkg::zvm_state_t st_reg;
    zvm_pkg::zvm_state_t st_next;
    zvm_pkg::zvm_src_t   auto_pick;
    zvm_pkg::zvm_src_t   man_pick;
    zvm_pkg::zvm_src_t   sel;
    logic                hit;
    logic [2:0]          avail;

    // both functions decode the offset; function 0 only is up to software
    assign hit = (cfg_addr == `ZVM_CTRL_OFF);

    // a socket counts only with its video mode set and activity seen
    assign avail = {st_reg.sync2[`ZVM_IDX_E].present,
                    st_reg.sync2[`ZVM_IDX_B].present & st_reg.ctrl.s1_mode,
                    st_reg.sync2[`ZVM_IDX_A].present & st_reg.ctrl.s0_mode};

    zvm_prio u_prio (
        .code  (st_reg.ctrl.prio),
        .avail (avail),
        .pick  (auto_pick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // source choice

    // manual path: select bit names a socket, used only if that socket is in video mode
    always_comb begin
        if (!st_reg.ctrl.src_sel) begin
            man_pick = st_reg.ctrl.s0_mode ? zvm_pkg::ZVM_SRC_S0 : zvm_pkg::ZVM_SRC_NONE;
        end else begin
            man_pick = st_reg.ctrl.s1_mode ? zvm_pkg::ZVM_SRC_S1 : zvm_pkg::ZVM_SRC_NONE;
        end
    end

    // priority field matters only in auto mode
    assign sel = st_reg.ctrl.auto_en ? auto_pick : man_pick;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_next = st_reg;
        // two flops on every pin before anything looks at it
        st_next.sync1[`ZVM_IDX_A] = '{present: sock0_vid_present, data: sock0_vid_i};
        st_next.sync1[`ZVM_IDX_B] = '{present: sock1_vid_present, data: sock1_vid_i};
        st_next.sync1[`ZVM_IDX_E] = '{present: ext_vid_present, data: ext_vid_i};
        st_next.sync2 = st_reg.sync1;
        // register write; a read in the same cycle returns the old value
        if (cfg_wr && hit) begin
            st_next.ctrl = zvm_pkg::zvm_ctrl_t'(cfg_wdata);
        end
        st_next.rdata = (cfg_rd && hit) ? 8'(st_reg.ctrl) : `ZVM_RD_IDLE;
        // routed data, zero when nothing is chosen
        st_next.src = sel;
        unique case (sel)
            zvm_pkg::ZVM_SRC_S0:  st_next.out_data = st_reg.sync2[`ZVM_IDX_A].data;
            zvm_pkg::ZVM_SRC_S1:  st_next.out_data = st_reg.sync2[`ZVM_IDX_B].data;
            zvm_pkg::ZVM_SRC_EXT: st_next.out_data = st_reg.sync2[`ZVM_IDX_E].data;
            zvm_pkg::ZVM_SRC_NONE: st_next.out_data = '0;
        endcase
        // outgoing port drivers follow the enable bit alone
        st_next.out_oe = st_reg.ctrl.drive_en;
        // card side drivers are turned off so the card may drive video in
        st_next.card1_oe = !st_reg.ctrl.s1_mode;
        st_next.card0_oe = !st_reg.ctrl.s0_mode;
    end

    // single register for all state; synchronous reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.ctrl <= zvm_pkg::zvm_ctrl_t'(`ZVM_CTRL_RST);
            st_reg.src <= zvm_pkg::ZVM_SRC_NONE;
            st_reg.card0_oe <= 1'b1;
            st_reg.card1_oe <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flops

    assign cfg_rdata   = st_reg.rdata;
    assign vid_out_o   = st_reg.out_data;
    assign vid_out_oe  = st_reg.out_oe;
    assign card0_if_oe = st_reg.card0_oe;
    assign card1_if_oe = st_reg.card1_oe;
    assign active_src  = st_reg.src;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // writing the enable clear floats the port two edges later
    chk_oe_off_write: assert property (
        (cfg_wr && hit && !cfg_wdata[7]) |=> ##1 !vid_out_oe)
        else $error("video port still driven after enable cleared");

    // writing the enable set drives the port two edges later
    chk_oe_on_write: assert property (
        (cfg_wr && hit && cfg_wdata[7]) |=> ##1 vid_out_oe)
        else $error("video port not driven after enable set");

    // manual socket 0 choice passes its synced data
    chk_manual_sock0: assert property (
        (!st_reg.ctrl.auto_en && !st_reg.ctrl.src_sel && st_reg.ctrl.s0_mode)
        |=> (active_src == zvm_pkg::ZVM_SRC_S0)
            && (vid_out_o == $past(st_reg.sync2[`ZVM_IDX_A].data)))
        else $error("manual socket 0 route wrong");

    // manual socket 1 choice passes its synced data
    chk_manual_sock1: assert property (
        (!st_reg.ctrl.auto_en && st_reg.ctrl.src_sel && st_reg.ctrl.s1_mode)
        |=> (active_src == zvm_pkg::ZVM_SRC_S1)
            && (vid_out_o == $past(st_reg.sync2[`ZVM_IDX_B].data)))
        else $error("manual socket 1 route wrong");

    // without auto mode the external source is never chosen
    chk_auto_off_ext: assert property (
        !st_reg.ctrl.auto_en |=> active_src != zvm_pkg::ZVM_SRC_EXT)
        else $error("external source chosen with auto-detect off");

    // priority changes alone do not move the choice in manual mode
    chk_prio_ignored: assert property (
        (!st_reg.ctrl.auto_en && $stable(st_reg.ctrl.src_sel)
         && $stable(st_reg.ctrl.s0_mode) && $stable(st_reg.ctrl.s1_mode)
         && !$stable(st_reg.ctrl.prio) && !$past(st_reg.ctrl.auto_en))
        |=> $stable(active_src))
        else $error("priority field moved the manual choice");

    // code 000 with slot A ready picks slot A
    chk_prio_a_first: assert property (
        (st_reg.ctrl.auto_en && st_reg.ctrl.prio == `ZVM_PRIO_ABE && avail[0])
        |=> active_src == zvm_pkg::ZVM_SRC_S0)
        else $error("slot A not first for code 000");

    // code 011 with B gone and external ready picks external over A
    chk_prio_bea: assert property (
        (st_reg.ctrl.auto_en && st_reg.ctrl.prio == `ZVM_PRIO_BEA && !avail[1] && avail[2])
        |=> active_src == zvm_pkg::ZVM_SRC_EXT)
        else $error("external not second for code 011");

    // code 100 with external ready picks external
    chk_prio_ext_first: assert property (
        (st_reg.ctrl.auto_en && st_reg.ctrl.prio == `ZVM_PRIO_EAB && avail[2])
        |=> active_src == zvm_pkg::ZVM_SRC_EXT)
        else $error("external not first for code 100");

    // socket 1 mode write turns its card drivers off two edges later
    chk_card1_input: assert property (
        (cfg_wr && hit && cfg_wdata[1]) |=> ##1 !card1_if_oe)
        else $error("socket 1 card drivers still on in video mode");

    // socket 0 mode write turns its card drivers off two edges later
    chk_card0_input: assert property (
        (cfg_wr && hit && cfg_wdata[0]) |=> ##1 !card0_if_oe)
        else $error("socket 0 card drivers still on in video mode");

    // a clear enable keeps the port floating on the next edge
    chk_oe_hold_off: assert property (
        !st_reg.ctrl.drive_en |=> !vid_out_oe)
        else $error("video port driven while enable clear");

    // socket 1 card drivers come back once its video mode is clear
    chk_card1_restore: assert property (
        !st_reg.ctrl.s1_mode |=> card1_if_oe)
        else $error("socket 1 card drivers off outside video mode");

    // socket 0 card drivers come back once its video mode is clear
    chk_card0_restore: assert property (
        !st_reg.ctrl.s0_mode |=> card0_if_oe)
        else $error("socket 0 card drivers off outside video mode");

    // auto mode with nothing available routes nothing
    chk_auto_none: assert property (
        (st_reg.ctrl.auto_en && !(|avail)) |=> active_src == zvm_pkg::ZVM_SRC_NONE)
        else $error("source chosen with nothing available");

    // code 001 with A gone and external ready picks external over B
    chk_prio_aeb: assert property (
        (st_reg.ctrl.auto_en && st_reg.ctrl.prio == `ZVM_PRIO_AEB && !avail[0] && avail[2])
        |=> active_src == zvm_pkg::ZVM_SRC_EXT)
        else $error("external not second for code 001");

    // main scenarios
    cov_manual_drive: cover property (
        vid_out_oe && active_src == zvm_pkg::ZVM_SRC_S1);
    cov_auto_ext: cover property (
        st_reg.ctrl.auto_en && active_src == zvm_pkg::ZVM_SRC_EXT);
    cov_auto_fallback: cover property (
        st_reg.ctrl.auto_en && st_reg.ctrl.prio == `ZVM_PRIO_BAE
        && !avail[1] && avail[0] ##1 active_src == zvm_pkg::ZVM_SRC_S0);
    cov_readback: cover property (
        cfg_rd && hit && st_reg.ctrl.drive_en);

endmodule : zvm_mux

// ---- verif/zvm_src_model.sv ----
// Purpose: behavioural sockets and external source feeding the routing block
// Assumes: the bench moves want off the rising edge
// Notes:   an idle source inverts its data each cycle so stale values match only on alternate cycles
`timescale 1ns/10ps
`include "zvm_cfg.svh"

module zvm_src_model #(
    parameter logic [2:0][`ZVM_VID_W-1:0] PAT = '0
) (
    input  wire logic               clk_sys,
    input  wire logic [2:0]         want,
    output zvm_pkg::zvm_vid_t [2:0] vid
);
    ////////////////////////////////////////////////////////////////////////////////
    // a live source holds its pattern; a quiet one must not look like it
    initial vid = '0;
    always @(posedge clk_sys) begin
        for (int i = 0; i < 3; i++) begin
            vid[i].present <= want[i];
            vid[i].data    <= want[i] ? PAT[i] : ~vid[i].data;
        end
    end
endmodule : zvm_src_model

// ---- verif/tb_zoomed_video_port_mux.sv ----
// Purpose: self-checking bench for the video port routing block
// Assumes: outputs settle within three edges of any input or control change
// Notes:   every access goes to function 0; codes above 100 are never written
`timescale 1ns/10ps
`include "zvm_cfg.svh"

module tb_zoomed_video_port_mux;
    // slot a, slot b, external patterns at index 0, 1, 2; literal lists index 2 first
    localparam logic [2:0][15:0] PAT = {16'h5e3c, 16'h4b2d, 16'h3a1f};
    localparam int ORD [5][3] = '{'{0,1,2}, '{0,2,1}, '{1,0,2}, '{1,2,0}, '{2,0,1}};

    logic                        clk_sys;
    logic                        rst;
    logic [7:0]                  cfg_addr;
    logic                        cfg_wr;
    logic                        cfg_rd;
    logic [7:0]                  cfg_wdata;
    logic [7:0]                  cfg_rdata;
    logic [2:0]                  want;
    zvm_pkg::zvm_vid_t [2:0]     vid;
    logic [`ZVM_VID_W-1:0]       vid_out_o;
    logic                        vid_out_oe;
    logic                        card0_if_oe;
    logic                        card1_if_oe;
    logic [3:0]                  active_src;
    int                          fail_count;
    int                          checks;
    int                          cycles;

    ////////////////////////////////////////////////////////////////////////////////
    zvm_src_model #(.PAT(PAT)) src (.clk_sys(clk_sys), .want(want), .vid(vid));

    zvm_mux uut (
        .clk_sys(clk_sys), .rst(rst), .cfg_func(1'b0),
        .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata),
        .sock0_vid_i(vid[0].data), .sock0_vid_present(vid[0].present),
        .sock1_vid_i(vid[1].data), .sock1_vid_present(vid[1].present),
        .ext_vid_i(vid[2].data), .ext_vid_present(vid[2].present),
        .vid_out_o(vid_out_o), .vid_out_oe(vid_out_oe), .card0_if_oe(card0_if_oe),
        .card1_if_oe(card1_if_oe), .active_src(active_src)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard; the whole run needs well under a thousand cycles
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 3000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic stop_test;
        if (fail_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one-cycle strobes, launched and dropped on falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        cfg_addr  = a;
        cfg_wdata = d;
        cfg_wr    = 1'b1;
        @(negedge clk_sys);
        cfg_wr = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask : wr

    // answer stands one cycle, then the bus falls back to zero
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        cfg_addr = a;
        cfg_rd   = 1'b1;
        @(negedge clk_sys);
        cfg_rd = 1'b0;
        check(16'(cfg_rdata), 16'(exp));
        @(negedge clk_sys);
        check(16'(cfg_rdata), 16'h0000);
    endtask : rd

    task automatic port(input logic [3:0] s, input logic [15:0] d, input logic [1:0] oe);
        repeat (4) @(negedge clk_sys);
        check(16'(active_src), 16'(s));
        check(vid_out_o, d);
        check(16'({card1_if_oe, card0_if_oe}), 16'(oe));
    endtask : port

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(8'h84, 8'h00);
        check(16'(vid_out_oe), 16'h0000);
        port(4'h1, 16'h0000, 2'h3);
    endtask : t_reset

    // drive enable both ways, plus a stray offset that must be ignored
    task automatic t_drive;
        wr(8'h84, 8'h80);
        check(16'(vid_out_oe), 16'h0001);
        wr(8'h85, 8'hff);
        rd(8'h85, 8'h00);
        rd(8'h84, 8'h80);
        wr(8'h84, 8'h00);
        check(16'(vid_out_oe), 16'h0000);
    endtask : t_drive

    task automatic t_manual;
        want = 3'h7;
        wr(8'h84, 8'h81);
        port(4'h2, PAT[0], 2'h2);
        wr(8'h84, 8'hc2);
        port(4'h4, PAT[1], 2'h1);
        wr(8'h84, 8'hc1);
        port(4'h1, 16'h0000, 2'h2);
        // only the priority field moves between these two writes
        wr(8'h84, 8'h81);
        wr(8'h84, 8'h91);
        port(4'h2, PAT[0], 2'h2);
    endtask : t_manual

    // strip the leading sources of each order one at a time
    task automatic t_auto;
        for (int c = 0; c < 5; c++) begin
            for (int k = 0; k < 4; k++) begin
                want = 3'h7;
                for (int j = 0; j < k; j++) want[ORD[c][j]] = 1'b0;
                wr(8'h84, 8'ha3 | 8'(c << 2));
                if (k == 3) begin
                    port(4'h1, 16'h0000, 2'h0);
                end else begin
                    port(4'h2 << ORD[c][k], PAT[ORD[c][k]], 2'h0);
                end
            end
        end
    endtask : t_auto

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst        = 1'b1;
        cfg_addr   = 8'h00;
        cfg_wr     = 1'b0;
        cfg_rd     = 1'b0;
        cfg_wdata  = 8'h00;
        want       = 3'h0;
        fail_count = 0;
        checks     = 0;
        cycles     = 0;
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        t_reset();
        t_drive();
        t_manual();
        t_auto();
        stop_test();
    end
endmodule : tb_zoomed_video_port_mux
